// File: hw/pcf_core_ctl.sv
// Program counter, banked flags, return stack and core register mapping
//
// Notes on behaviour
// - Pointers at 80h and 81h as RAM
// - Short-direct slots at 82h and 83h
// - Direct/bit access; pointers drive indirect fetch
// - Twelve-bit program counter, 4096 bytes reach
// - Counter steps by one after fetch
// - Relative branch adds signed offset to counter
// - Load target, vectors or stack top
// - Three flag pairs, only current used
// - Entry selects pair; exit restores previous
// - Pairs reachable in own mode, cleared only by reset
// - Carry: arithmetic, bit test, rotate feed
// - Zero set on zero result; bit test leaves it unchanged
// - Leave reset in urgent mode
// - Six twelve-bit levels, no pointer visible
// - Push shifts down, sixth lost
// - Pop loads counter, shifts up
// - Empty pop holds stack, continues
// - Only return addresses are stacked
// - Lower half banked by page code
// - Page 1 aliases static page
// - Sixty-four byte data window into ROM; not decoded here, 40h-7Fh reads 00h with no hit
// - Bit 11 high selects static page
// - Page select write-only, untouched by calls
`timescale 1ns/1ps
`include "pcf_regs.svh"
module pcf_core_ctl
  import pcf_pkg::*;
#(
  parameter int PW = `PCF_PC_W,
  parameter int RW = 13
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire pcf_pc_op_t   pc_op,
  input  wire logic [PW-1:0] pc_target,
  input  wire logic [7:0]   rel_offset,
  input  wire logic         fetch_step,
  input  wire logic [7:0]   rom_rdata,
  output logic [RW-1:0]     rom_addr,
  output logic              vec_busy,
  input  wire logic         ds_wr,
  input  wire logic         ds_rd,
  input  wire logic [7:0]   ds_addr,
  input  wire logic [7:0]   ds_wdata,
  output logic [7:0]        ds_rdata,
  output logic              ds_hit,
  output logic [7:0]        ind_ptr0,
  output logic [7:0]        ind_ptr1,
  input  wire pcf_flag_op_t flag_op,
  input  wire logic [8:0]   alu_sum,
  input  wire logic         bit_tested,
  output logic              carry,
  output logic              zero,
  output logic [PW-1:0]     pc,
  output pcf_mode_t         mode,
  output logic              stack_empty
);
  logic [PW-1:0]  pc_q;
  logic [PW-1:0]  pc_d;
  pcf_mode_t      mode_q;
  pcf_mode_t      prev_mode_q;
  logic [2:0]     carry_q;
  logic [2:0]     zero_q;
  logic [1:0]     idx;
  logic [7:0]     ptr0_q;
  logic [7:0]     ptr1_q;
  logic [7:0]     slot1_q;
  logic [7:0]     slotb_q;
  logic [1:0]     page_q;
  logic [7:0]     rdata_d;
  logic           hit_d;
  logic [RW-1:0]  fetch_addr;
  logic [RW-1:0]  rom_addr_d;
  pcf_vec_state_t vst_q;
  logic [PW-1:0]  vec_base_q;
  logic [7:0]     vec_lo_q;
  logic [PW-1:0]  rel_sum;
  logic           res_zero;
  logic           new_carry;
  logic           exit_op;

  pcf_stack_if #(.W(PW)) sif ();

  pcf_ret_stack #(.DEPTH(`PCF_STACK_DEPTH), .W(PW)) u_stack (
    .mclk (mclk),
    .srst (srst),
    .sif  (sif)
  );

  // ------------------------------------------------------------
  // Return stack control
  // ------------------------------------------------------------
  assign exit_op      = (pc_op == PCF_PC_SUBEX) || (pc_op == PCF_PC_INTEX);
  assign sif.push     = (vst_q == PCF_VEC_IDLE) && ((pc_op == PCF_PC_CALL) ||
                        (pc_op == PCF_PC_INTR) || (pc_op == PCF_PC_NMI));
  assign sif.pop      = (vst_q == PCF_VEC_IDLE) && exit_op;
  assign sif.push_val = pc_q;

  // ------------------------------------------------------------
  // Program counter
  // ------------------------------------------------------------
  assign rel_sum = pc_q + PW'({{4{rel_offset[7]}}, rel_offset});

  always_comb begin
    pc_d = pc_q;
    case (pc_op)
      PCF_PC_STEP:  pc_d = fetch_step ? pc_q + PW'(1) : pc_q;
      PCF_PC_JUMP,
      PCF_PC_CALL,
      PCF_PC_INTR:  pc_d = pc_target;
      PCF_PC_REL:   pc_d = rel_sum;
      PCF_PC_SUBEX,
      PCF_PC_INTEX: pc_d = sif.empty ? pc_q + PW'(1) : sif.top_val;
      default:      pc_d = pc_q;
    endcase
  end

  // Vector fetch sequencer for reset and urgent entry
  always_ff @(posedge mclk) begin
    if (srst) begin
      vst_q      <= PCF_VEC_LO;
      vec_base_q <= `PCF_RESET_VEC_LO;
      vec_lo_q   <= 8'h00;
    end else begin
      case (vst_q)
        PCF_VEC_IDLE: if (pc_op == PCF_PC_NMI) begin
          vst_q      <= PCF_VEC_LO;
          vec_base_q <= `PCF_NMI_VEC_LO;
        end
        PCF_VEC_LO:   vst_q <= PCF_VEC_HI;
        PCF_VEC_HI: begin
          vec_lo_q <= rom_rdata;
          vst_q    <= PCF_VEC_LOAD;
        end
        PCF_VEC_LOAD: vst_q <= PCF_VEC_IDLE;
        default:      vst_q <= PCF_VEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_q <= `PCF_RESET_VEC_LO;
    end else if (vst_q == PCF_VEC_LOAD) begin
      pc_q <= {rom_rdata[3:0], vec_lo_q};
    end else if (vst_q == PCF_VEC_IDLE) begin
      pc_q <= pc_d;
    end
  end

  // ------------------------------------------------------------
  // Mode and banked flags
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q      <= PCF_MODE_URGENT;
      prev_mode_q <= PCF_MODE_NORMAL;
    end else if (vst_q == PCF_VEC_IDLE) begin
      if (pc_op == PCF_PC_NMI) begin
        prev_mode_q <= mode_q;
        mode_q      <= PCF_MODE_URGENT;
      end else if (pc_op == PCF_PC_INTR) begin
        prev_mode_q <= mode_q;
        mode_q      <= PCF_MODE_INTR;
      end else if (pc_op == PCF_PC_INTEX) begin
        mode_q      <= prev_mode_q;
        prev_mode_q <= PCF_MODE_NORMAL;
      end
    end
  end

  always_comb begin
    case (mode_q)
      PCF_MODE_NORMAL: idx = 2'h0;
      PCF_MODE_INTR:   idx = 2'h1;
      PCF_MODE_URGENT: idx = 2'h2;
      default:         idx = 2'h2;
    endcase
  end

  assign res_zero = (alu_sum[7:0] == 8'h00);

  always_comb begin
    new_carry = carry_q[idx];
    case (flag_op)
      PCF_FL_ARITH: new_carry = alu_sum[8];
      PCF_FL_BTEST: new_carry = bit_tested;
      PCF_FL_ROTL:  new_carry = alu_sum[8];
      default:      new_carry = carry_q[idx];
    endcase
  end

  // Only the active pair is written; others keep their value
  always_ff @(posedge mclk) begin
    if (srst) begin
      carry_q <= 3'h0;
      zero_q  <= 3'h0;
    end else if (flag_op != PCF_FL_NONE) begin
      carry_q[idx] <= new_carry;
      if (flag_op != PCF_FL_BTEST) begin
        zero_q[idx] <= res_zero;
      end
    end
  end

  // ------------------------------------------------------------
  // Data-space registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      ptr0_q  <= 8'h00;
      ptr1_q  <= 8'h00;
      slot1_q <= 8'h00;
      slotb_q <= 8'h00;
    end else if (ds_wr) begin
      case (ds_addr)
        `PCF_ADDR_FIRST_PTR:  ptr0_q  <= ds_wdata;
        `PCF_ADDR_SECOND_PTR: ptr1_q  <= ds_wdata;
        `PCF_ADDR_SLOT_ONE:   slot1_q <= ds_wdata;
        `PCF_ADDR_SLOT_B:     slotb_q <= ds_wdata;
        default:              ;
      endcase
    end
  end

  // Page code has no reset; write-only, not disturbed by calls
  always_ff @(posedge mclk) begin
    if (ds_wr && ds_addr == `PCF_ADDR_PAGE_SEL) begin
      page_q <= ds_wdata[1:0];
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    hit_d   = 1'b0;
    case (ds_addr)
      `PCF_ADDR_FIRST_PTR: begin
        rdata_d = ptr0_q;
        hit_d   = 1'b1;
      end
      `PCF_ADDR_SECOND_PTR: begin
        rdata_d = ptr1_q;
        hit_d   = 1'b1;
      end
      `PCF_ADDR_SLOT_ONE: begin
        rdata_d = slot1_q;
        hit_d   = 1'b1;
      end
      `PCF_ADDR_SLOT_B: begin
        rdata_d = slotb_q;
        hit_d   = 1'b1;
      end
      default: begin
        rdata_d = 8'h00;
        hit_d   = 1'b0;
      end
    endcase
  end

  // Registered read port; bit ops are read-modify-write by the core
  always_ff @(posedge mclk) begin
    if (srst) begin
      ds_rdata <= 8'h00;
      ds_hit   <= 1'b0;
    end else begin
      ds_rdata <= ds_rd ? rdata_d : 8'h00;
      ds_hit   <= ds_rd && hit_d;
    end
  end

  // ------------------------------------------------------------
  // Program ROM addressing
  // ------------------------------------------------------------
  always_comb begin
    if (pc_q[`PCF_PC_STATIC_BIT]) begin
      fetch_addr = {`PCF_STATIC_PAGE, pc_q[10:0]};
    end else begin
      fetch_addr = {page_q, pc_q[10:0]};
    end
  end

  always_comb begin
    case (vst_q)
      PCF_VEC_LO: rom_addr_d = {`PCF_STATIC_PAGE, vec_base_q[10:0]};
      PCF_VEC_HI: rom_addr_d = {`PCF_STATIC_PAGE, vec_base_q[10:0] + 11'h001};
      default:    rom_addr_d = fetch_addr;
    endcase
  end

  // Window 40h-7Fh is not routed into ROM; data reads there return 00h without a hit
  always_ff @(posedge mclk) begin
    if (srst) begin
      rom_addr    <= '0;
      vec_busy    <= 1'b1;
      pc          <= '0;
      mode        <= PCF_MODE_URGENT;
      carry       <= 1'b0;
      zero        <= 1'b0;
      stack_empty <= 1'b1;
      ind_ptr0    <= 8'h00;
      ind_ptr1    <= 8'h00;
    end else begin
      rom_addr    <= rom_addr_d;
      vec_busy    <= (vst_q != PCF_VEC_IDLE);
      pc          <= pc_q;
      mode        <= mode_q;
      carry       <= carry_q[idx];
      zero        <= zero_q[idx];
      stack_empty <= sif.empty;
      ind_ptr0    <= ptr0_q;
      ind_ptr1    <= ptr1_q;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_reset_mode_urgent: assert property (@(posedge mclk)
    $fell(srst) |-> mode_q == PCF_MODE_URGENT)
    else $error("not in urgent mode after reset");
  a_pc_step_one: assert property (@(posedge mclk) disable iff (srst)
    vst_q == PCF_VEC_IDLE && pc_op == PCF_PC_STEP && fetch_step |=> pc_q == $past(pc_q) + 12'h001)
    else $error("counter did not step by one");
  a_pc_jump_load: assert property (@(posedge mclk) disable iff (srst)
    vst_q == PCF_VEC_IDLE && pc_op == PCF_PC_JUMP |=> pc_q == $past(pc_target))
    else $error("jump target not loaded");
  a_pc_rel_add: assert property (@(posedge mclk) disable iff (srst)
    vst_q == PCF_VEC_IDLE && pc_op == PCF_PC_REL |=> pc_q == $past(rel_sum))
    else $error("relative branch sum wrong");
  a_mode_intr_entry: assert property (@(posedge mclk) disable iff (srst)
    vst_q == PCF_VEC_IDLE && pc_op == PCF_PC_INTR |=> mode_q == PCF_MODE_INTR)
    else $error("interrupt entry mode wrong");
  a_flag_other_hold: assert property (@(posedge mclk) disable iff (srst)
    idx == 2'h0 |=> carry_q[2] == $past(carry_q[2]) && zero_q[1] == $past(zero_q[1]))
    else $error("inactive flag pair changed");
  a_zero_flag_set: assert property (@(posedge mclk) disable iff (srst)
    flag_op == PCF_FL_ARITH ##1 idx == $past(idx) |-> zero_q[idx] == ($past(alu_sum[7:0]) == 8'h00))
    else $error("zero flag wrong");
  a_static_fetch_map: assert property (@(posedge mclk) disable iff (srst)
    vst_q == PCF_VEC_IDLE && pc_q[11] |=> rom_addr[12:11] == 2'h1)
    else $error("static page not selected");
  a_ptr_write_read: assert property (@(posedge mclk) disable iff (srst)
    ds_wr && ds_addr == 8'h80 ##1 ds_rd && ds_addr == 8'h80 && !ds_wr |=> ds_rdata == $past(ds_wdata, 2))
    else $error("first pointer readback wrong");

  c_call_seen:  cover property (@(posedge mclk) disable iff (srst) sif.push);
  c_intex_seen: cover property (@(posedge mclk) disable iff (srst) pc_op == PCF_PC_INTEX && !sif.empty);
  c_empty_pop:  cover property (@(posedge mclk) disable iff (srst) sif.pop && sif.empty);
  c_nmi_entry:  cover property (@(posedge mclk) disable iff (srst) vst_q == PCF_VEC_LOAD);
endmodule

// File: hw/pcf_regs.svh
// Offsets, field positions, sizes and vector addresses of the program-control block
`ifndef PCF_REGS_SVH
`define PCF_REGS_SVH
`define PCF_ADDR_FIRST_PTR   8'h80
`define PCF_ADDR_SECOND_PTR  8'h81
`define PCF_ADDR_SLOT_ONE    8'h82
`define PCF_ADDR_SLOT_B      8'h83
`define PCF_ADDR_PAGE_SEL    8'hCA
`define PCF_ADDR_WIN_LO      8'h40
`define PCF_ADDR_WIN_HI      8'h7F
`define PCF_PC_W             12
`define PCF_STACK_DEPTH      6
`define PCF_PC_STATIC_BIT    11
`define PCF_RESET_VEC_LO     12'hFFE
`define PCF_NMI_VEC_LO       12'hFFC
`define PCF_STATIC_PAGE      2'h1
`endif

// File: hw/pcf_pkg.sv
// Types shared by the program-control block
package pcf_pkg;
  typedef enum logic [2:0] {
    PCF_MODE_NORMAL = 3'h1,
    PCF_MODE_INTR   = 3'h2,
    PCF_MODE_URGENT = 3'h4
  } pcf_mode_t;

  typedef enum logic [3:0] {
    PCF_PC_HOLD   = 4'h0,
    PCF_PC_STEP   = 4'h1,
    PCF_PC_JUMP   = 4'h2,
    PCF_PC_CALL   = 4'h3,
    PCF_PC_REL    = 4'h4,
    PCF_PC_INTR   = 4'h5,
    PCF_PC_NMI    = 4'h6,
    PCF_PC_SUBEX  = 4'h7,
    PCF_PC_INTEX  = 4'h8
  } pcf_pc_op_t;

  typedef enum logic [2:0] {
    PCF_FL_NONE  = 3'h0,
    PCF_FL_ARITH = 3'h1,
    PCF_FL_LOGIC = 3'h2,
    PCF_FL_BTEST = 3'h3,
    PCF_FL_ROTL  = 3'h4
  } pcf_flag_op_t;

  typedef enum logic [3:0] {
    PCF_VEC_IDLE = 4'h1,
    PCF_VEC_LO   = 4'h2,
    PCF_VEC_HI   = 4'h4,
    PCF_VEC_LOAD = 4'h8
  } pcf_vec_state_t;
endpackage

// File: hw/pcf_stack_if.sv
// Push/pop carrier between the core and its return stack
`timescale 1ns/1ps
interface pcf_stack_if #(parameter int W = 12);
  logic         push;
  logic         pop;
  logic [W-1:0] push_val;
  logic [W-1:0] top_val;
  logic         empty;
  modport core  (output push, output pop, output push_val, input top_val, input empty);
  modport stack (input push, input pop, input push_val, output top_val, output empty);
endinterface

// File: hw/pcf_ret_stack.sv
// Six-level shifting return-address stack
`timescale 1ns/1ps
`include "pcf_regs.svh"
module pcf_ret_stack
  import pcf_pkg::*;
#(
  parameter int DEPTH = `PCF_STACK_DEPTH,
  parameter int W     = `PCF_PC_W
) (
  input  wire logic  mclk,
  input  wire logic  srst,
  pcf_stack_if.stack sif
);
  logic [W-1:0]   lvl_q [DEPTH];
  logic [DEPTH:0] fill_q;

  assign sif.top_val = lvl_q[0];
  assign sif.empty   = fill_q[0];

  // ------------------------------------------------------------
  // Shift levels
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sif.push) begin
      lvl_q[0] <= sif.push_val;
      for (int i = 1; i < DEPTH; i++) begin
        lvl_q[i] <= lvl_q[i-1];
      end
    end else if (sif.pop && !fill_q[0]) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        lvl_q[i] <= lvl_q[i+1];
      end
    end
  end

  // One-hot occupancy: bit k set means k levels held; saturates both ends
  always_ff @(posedge mclk) begin
    if (srst) begin
      fill_q <= '0;
      fill_q[0] <= 1'b1;
    end else if (sif.push && !fill_q[DEPTH]) begin
      fill_q <= {fill_q[DEPTH-1:0], 1'b0};
    end else if (sif.pop && !sif.push && !fill_q[0]) begin
      fill_q <= {1'b0, fill_q[DEPTH:1]};
    end
  end

  a_stack_empty_pop: assert property (@(posedge mclk) disable iff (srst)
    sif.pop && !sif.push && fill_q[0] |=> fill_q[0])
    else $error("pop on empty stack moved occupancy");
  a_stack_push_top: assert property (@(posedge mclk) disable iff (srst)
    sif.push |=> lvl_q[0] == $past(sif.push_val))
    else $error("pushed value not on top");
endmodule

// File: verification/pcf_rom_model.sv
// Program ROM model answering the fetch address of the core
`timescale 1ns/1ps
module pcf_rom_model #(
  parameter logic [11:0] RST_VEC = 12'h123,
  parameter logic [11:0] NMI_VEC = 12'h456
) (
  input  wire logic [12:0] rom_addr,
  output logic [7:0]       rom_rdata
);
  // Vectors sit in physical page 1, seen as the static top
  always_comb begin
    case (rom_addr)
      13'h0FFE: rom_rdata = RST_VEC[7:0];
      13'h0FFF: rom_rdata = {4'hA, RST_VEC[11:8]};
      13'h0FFC: rom_rdata = NMI_VEC[7:0];
      13'h0FFD: rom_rdata = {4'h5, NMI_VEC[11:8]};
      default:  rom_rdata = rom_addr[7:0] ^ {3'h0, rom_addr[12:8]};
    endcase
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the program-control block
`timescale 1ns/1ps
module testbench
  import pcf_pkg::*;
;
  localparam logic [11:0] RV = 12'h123;
  localparam logic [11:0] NV = 12'h456;
  typedef struct { int kind; logic [15:0] exp; } pcf_note_t;
  logic         mclk, srst, fetch_step, ds_wr, ds_rd, bit_tested;
  logic         vec_busy, ds_hit, carry, zero, stack_empty;
  pcf_pc_op_t   pc_op;
  pcf_flag_op_t flag_op;
  pcf_mode_t    mode;
  logic [11:0]  pc_target, pc, pc_e, a, p;
  logic [7:0]   rel_offset, rom_rdata, ds_addr, ds_wdata, ds_rdata, ind_ptr0, ind_ptr1, v;
  logic [8:0]   alu_sum;
  logic [12:0]  rom_addr;
  int           n_mismatch = 0;
  int           tests_run = 0;
  integer       seed = 32'h99DF4175;
  pcf_note_t    q[$];
  logic [11:0]  stk[$];
  event         obs;

  pcf_core_ctl u_pcf_core_ctl (.mclk(mclk), .srst(srst), .pc_op(pc_op), .pc_target(pc_target),
    .rel_offset(rel_offset), .fetch_step(fetch_step), .rom_rdata(rom_rdata),
    .rom_addr(rom_addr), .vec_busy(vec_busy), .ds_wr(ds_wr), .ds_rd(ds_rd), .ds_addr(ds_addr),
    .ds_wdata(ds_wdata), .ds_rdata(ds_rdata), .ds_hit(ds_hit), .ind_ptr0(ind_ptr0),
    .ind_ptr1(ind_ptr1), .flag_op(flag_op), .alu_sum(alu_sum), .bit_tested(bit_tested),
    .carry(carry), .zero(zero), .pc(pc), .mode(mode), .stack_empty(stack_empty));
  pcf_rom_model #(.RST_VEC(RV), .NMI_VEC(NV)) u_pcf_rom_model (.rom_addr(rom_addr),
    .rom_rdata(rom_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Checking and drive tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] seen_of(input int kind);
    case (kind)
      0: seen_of = {4'h0, pc};
      1: seen_of = {13'h0, mode};
      2: seen_of = {15'h0, carry};
      3: seen_of = {15'h0, zero};
      4: seen_of = {15'h0, stack_empty};
      5: seen_of = {8'h0, ds_rdata};
      6: seen_of = {15'h0, ds_hit};
      7: seen_of = {3'h0, rom_addr};
      8: seen_of = {8'h0, ind_ptr0};
      10: seen_of = {15'h0, vec_busy};
      default: seen_of = {8'h0, ind_ptr1};
    endcase
  endfunction

  // Oldest note is compared with the settled outputs
  initial begin
    pcf_note_t n;
    forever begin
      @(obs);
      while (q.size() > 0) begin
        n = q.pop_front();
        check(seen_of(n.kind), n.exp);
      end
    end
  end

  task automatic note(input int kind, input logic [15:0] exp);
    q.push_back('{kind, exp});
    -> obs;
  endtask

  task automatic flags(input logic c, input logic z, input pcf_mode_t m);
    note(2, {15'h0, c});
    note(3, {15'h0, z});
    note(1, {13'h0, m});
  endtask

  task automatic op(input pcf_pc_op_t o, input logic [11:0] t);
    pc_op = o;
    pc_target = t;
    @(negedge mclk);
    pc_op = PCF_PC_HOLD;
    repeat (3) @(negedge mclk);
  endtask

  task automatic fop(input pcf_flag_op_t f, input logic [8:0] s, input logic b);
    flag_op = f;
    alu_sum = s;
    bit_tested = b;
    @(negedge mclk);
    flag_op = PCF_FL_NONE;
    repeat (2) @(negedge mclk);
  endtask

  task automatic wait_vec;
    int i;
    i = 0;
    while (vec_busy !== 1'b0 && i < 20) begin
      @(negedge mclk);
      i++;
    end
    if (i == 20) n_mismatch++;
    repeat (2) @(negedge mclk);
  endtask

  task automatic ds_acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
    ds_wr = w;
    ds_rd = !w;
    ds_addr = ad;
    ds_wdata = d;
    // Strobes stay up until the next access or an explicit release
    @(negedge mclk);
  endtask

  task automatic stop_test;
    $display("counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #50000;
    n_mismatch++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1; pc_op = PCF_PC_HOLD; pc_target = 12'h0; rel_offset = 8'h0; fetch_step = 1'b0;
    ds_wr = 1'b0; ds_rd = 1'b0; ds_addr = 8'h0; ds_wdata = 8'h0;
    flag_op = PCF_FL_NONE; alu_sum = 9'h0; bit_tested = 1'b0;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    wait_vec();
    note(0, {4'h0, RV});
    flags(1'b0, 1'b0, PCF_MODE_URGENT);
    note(4, 16'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      ds_acc(1'b1, 8'h80 + 8'(i), v);
      ds_acc(1'b0, 8'h80 + 8'(i), 8'h0);
      note(5, {8'h0, v});
      note(6, 16'h1);
      if (i < 2) note(8 + i, {8'h0, v});
    end
    for (int i = 0; i < 2; i++) begin
      ds_acc(1'b1, i ? 8'h84 : 8'hCA, 8'h3);
      ds_acc(1'b0, i ? 8'h84 : 8'hCA, 8'h0);
      note(6, 16'h0);
      note(5, 16'h0);
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      ds_acc(1'b1, 8'hCA, 8'(c));
      ds_wr = 1'b0;
      a = {1'b0, 11'($random(seed))};
      op(PCF_PC_JUMP, a);
      note(0, {4'h0, a});
      note(7, {3'h0, 2'(c), a[10:0]});
      op(PCF_PC_JUMP, a | 12'h800);
      note(7, {3'h0, 2'h1, a[10:0]});
    end
    pc_e = a | 12'h800;
    fetch_step = 1'b1;
    op(PCF_PC_STEP, 12'h0);
    fetch_step = 1'b0;
    pc_e = pc_e + 12'h1;
    note(0, {4'h0, pc_e});
    op(PCF_PC_STEP, 12'h0);
    note(0, {4'h0, pc_e});
    rel_offset = 8'($random(seed)) | 8'h80;
    op(PCF_PC_REL, 12'h0);
    pc_e = pc_e + {{4{rel_offset[7]}}, rel_offset};
    note(0, {4'h0, pc_e});
    $display("test counter done");
    for (int i = 0; i < 7; i++) begin
      a = {1'b0, 11'($random(seed))};
      op(PCF_PC_CALL, a);
      stk.push_front(pc_e);
      if (stk.size() > 6) void'(stk.pop_back());
      pc_e = a;
      note(0, {4'h0, a});
      note(4, 16'h0);
    end
    note(7, {3'h0, 2'h3, a[10:0]});
    for (int i = 0; i < 7; i++) begin
      op(PCF_PC_SUBEX, 12'h0);
      pc_e = (stk.size() > 0) ? stk.pop_front() : pc_e + 12'h1;
      note(0, {4'h0, pc_e});
      note(4, {15'h0, stk.size() == 0});
    end
    $display("test stack done");
    fop(PCF_FL_ARITH, 9'h100, 1'b0);
    flags(1'b1, 1'b1, PCF_MODE_URGENT);
    op(PCF_PC_INTEX, 12'h0);
    pc_e = pc_e + 12'h1;
    note(0, {4'h0, pc_e});
    flags(1'b0, 1'b0, PCF_MODE_NORMAL);
    fop(PCF_FL_ARITH, 9'h105, 1'b0);
    flags(1'b1, 1'b0, PCF_MODE_NORMAL);
    p = pc_e;
    op(PCF_PC_INTR, 12'h300);
    note(0, 16'h0300);
    flags(1'b0, 1'b0, PCF_MODE_INTR);
    fop(PCF_FL_LOGIC, 9'h000, 1'b0);
    note(3, 16'h1);
    fop(PCF_FL_BTEST, 9'h0FF, 1'b1);
    flags(1'b1, 1'b1, PCF_MODE_INTR);
    op(PCF_PC_INTEX, 12'h0);
    note(0, {4'h0, p});
    flags(1'b1, 1'b0, PCF_MODE_NORMAL);
    op(PCF_PC_NMI, 12'h0);
    note(10, 16'h1);
    wait_vec();
    note(0, {4'h0, NV});
    flags(1'b1, 1'b1, PCF_MODE_URGENT);
    fop(PCF_FL_ROTL, 9'h0FF, 1'b0);
    note(2, 16'h0);
    op(PCF_PC_INTEX, 12'h0);
    note(0, {4'h0, p});
    flags(1'b1, 1'b0, PCF_MODE_NORMAL);
    $display("test flags done");
    @(negedge mclk);
    stop_test();
  end
endmodule
